// >>> bus_master_model.sv
// Two-wire bus master: drives the link clock and pulls the data line low
`default_nettype none

module bus_master_model (
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Phases are five 48 ns link steps so the device's synchronisers see each edge
    localparam int HALF = 240;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // Serves as repeated start too
    task automatic begin_frame();
        o_sda_low = 1'b0;
        #(HALF / 2);
        o_scl = 1'b1;
        #HALF;
        o_sda_low = 1'b1;
        #HALF;
        o_scl = 1'b0;
        #(HALF / 2);
    endtask : begin_frame
    task automatic end_frame();
        o_sda_low = 1'b1;
        #(HALF / 2);
        o_scl = 1'b1;
        #HALF;
        o_sda_low = 1'b0;
        #HALF;
    endtask : end_frame
    // Level held over the whole high phase
    task automatic clk_bit(input logic b, output logic s);
        o_sda_low = !b;
        #(HALF / 2);
        o_scl = 1'b1;
        #HALF;
        s = i_sda_line;
        o_scl = 1'b0;
        #(HALF / 2);
    endtask : clk_bit
    // MSB first, then the acknowledge clock; a_bit low acknowledges a read byte
    task automatic xfer(input logic [7:0] v, input logic a_bit, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], r[i]);
        end
        clk_bit(a_bit, ack);
    endtask : xfer
endmodule : bus_master_model

`default_nettype wire

// >>> rtc_pkg.sv
// Constants, types and helper functions for the serial-bus real-time clock
//
// Operation
// - Ninth bit after each byte is acknowledge
// - Addressed receiver acknowledges every byte
// - Acknowledge low holds through clock high
// - On master no-acknowledge, release data line
// - Pointer advances only on master acknowledge (the code also advances it after every written data byte)
// - Send consecutive bytes until STOP
// - Bare read starts at current pointer
// - First write byte loads pointer, rest stored
// - Acknowledge address, word address, data bytes
// - Power fail deselects, blocks access, floats pins
// - Protection held for interval after recovery
// - Century flag toggles only when enabled
// - Halt bit stops oscillator and timekeeping
// - Weekday in low three bits, 1-7
// - All time fields are BCD
// - Reading time postpones update, max 250 ms
// - Control register accessible on its own
// - Bus address D0h, 64 bytes
// - Five-bit calibration magnitude, sign in bit 5
// - Test pin: 512 Hz or output level
// - Control resets test 0, level 1
`default_nettype none

package rtc_pkg;

    localparam logic [7:0] DEV_ADDR = 8'hD0;
    localparam logic [5:0] IDX_CTRL = 6'h07;
    localparam logic [5:0] IDX_RAM_LO = 6'h08;
    localparam int unsigned MEM_BYTES = 64;
    localparam int unsigned N_TIME = 7;
    localparam int unsigned HALT_BIT = 7;
    localparam int unsigned CEB_BIT = 7;
    localparam int unsigned CB_BIT = 6;
    localparam int unsigned OUT_BIT = 7;
    localparam int unsigned FT_BIT = 6;
    localparam int unsigned SIGN_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    localparam logic [7:0] MIN_MASK = 8'h7F;
    localparam logic [7:0] DAY_MASK = 8'h07;
    localparam logic [7:0] DATE_MASK = 8'h3F;
    localparam logic [7:0] MON_MASK = 8'h1F;

    localparam int unsigned OSC_HZ = 32768;
    localparam int unsigned WAVE_HZ = 512;
    localparam int unsigned WAVE_HALF = OSC_HZ / WAVE_HZ / 2;
    localparam int unsigned CAL_ADD_CYC = 256;
    localparam int unsigned CAL_SUB_CYC = 128;

    localparam int unsigned SYS_HZ = 100_000_000;
    localparam int unsigned DEFER_MS = 250;
    localparam int unsigned PROTECT_MS = 200;
    localparam int unsigned DEFER_CYC = DEFER_MS * (SYS_HZ / 1000);
    localparam int unsigned PROTECT_CYC = PROTECT_MS * (SYS_HZ / 1000);

    typedef enum logic [2:0] {
        ST_ADDR = 3'h0,
        ST_WORD = 3'h1,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h2,
        ST_IGNORE = 3'h6
    } link_state_e;

    // Returns {wrapped, next}; BCD order matches binary order
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v >= hi) begin
            return {1'b1, lo};
        end else if (v[3:0] == 4'h9) begin
            return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        end
        return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction : bcd_inc

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : month_len

endpackage : rtc_pkg

`default_nettype wire

// >>> rtc_serial_clock.sv
// Serial-bus slave real-time clock: bus engine, register file, power guard
`default_nettype none

module rtc_serial_clock
    import rtc_pkg::*;
#(
    parameter int unsigned DEFER_CYCLES = DEFER_CYC,
    parameter int unsigned PROTECT_CYCLES = PROTECT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_osc_32k,
    input wire logic i_below_power_fail_threshold,
    output logic o_test_or_level_pin_o,
    output logic o_test_or_level_pin_oe
);

    // ------------------------
    // Declarations
    // ------------------------

    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] pf_q;
    logic prot_q;
    logic [24:0] prot_cnt_q;
    logic link_clr_q;
    logic armed_q;
    logic start_cond;
    logic stop_cond;
    link_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic ack_q;
    logic [5:0] ptr_q;
    logic wr_en_q;
    logic [5:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic xfer_tgl_q;
    logic sda_low_q;
    logic [7:0] tx_q;
    logic rd_busy_q;
    logic [2:0] tgl_q;
    logic [1:0] busy_q;
    logic xfer_fire;
    logic [5:0] ptr_cap_q;
    logic [7:0] ctrl_q;
    logic [7:0] shadow_q [N_TIME];
    logic [7:0] ram_q [IDX_RAM_LO:MEM_BYTES-1];
    logic [7:0] rd_byte_q;
    logic upd_pend_q;
    logic [24:0] defer_cnt_q;
    logic copy_now;
    logic ld_en;
    logic [7:0] t_sec, t_min, t_hour, t_day, t_date, t_mon, t_year;
    logic t_tick;
    logic t_wave;

    // ------------------------
    // Pin synchronisers (system clock)
    // ------------------------

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            pf_q <= 2'h0;
        end else begin
            scl_q <= {scl_q[1:0], i_scl};
            sda_q <= {sda_q[1:0], i_sda_i};
            pf_q <= {pf_q[0], i_below_power_fail_threshold};
        end
    end

    assign start_cond = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop_cond = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

    // ------------------------
    // Power-fail guard
    // ------------------------

    // Protection also runs after reset, since supply state is unknown then
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prot_q <= 1'b1;
            prot_cnt_q <= '0;
        end else if (pf_q[1]) begin
            prot_q <= 1'b1;
            prot_cnt_q <= '0;
        end else if (prot_q) begin
            prot_cnt_q <= 25'(prot_cnt_q + 25'h1);
            if (prot_cnt_q == 25'(PROTECT_CYCLES - 1)) begin
                prot_q <= 1'b0;
            end
        end
    end

    // ------------------------
    // Frame control
    // ------------------------

    // Link logic held clear between frames; released only with the line clock low
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            link_clr_q <= 1'b1;
            armed_q <= 1'b0;
        end else if (prot_q) begin
            link_clr_q <= 1'b1;
            armed_q <= 1'b0;
        end else if (start_cond) begin
            link_clr_q <= 1'b1;
            armed_q <= 1'b1;
        end else if (stop_cond) begin
            link_clr_q <= 1'b1;
            armed_q <= 1'b0;
        end else if (armed_q && !scl_q[1]) begin
            link_clr_q <= 1'b0;
            armed_q <= 1'b0;
        end
    end

    // ------------------------
    // Link receive side (rising line clock)
    // ------------------------

    always_ff @(posedge i_scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= '0;
            shift_q <= '0;
            ack_q <= 1'b0;
        end else begin
            bit_cnt_q <= (bit_cnt_q == 4'h8) ? 4'h0 : 4'(bit_cnt_q + 4'h1);
            if (bit_cnt_q < 4'h8) begin
                shift_q <= {shift_q[6:0], i_sda_i};
            end
            if (bit_cnt_q == 4'h7) begin
                unique case (state_q)
                    ST_ADDR: ack_q <= (shift_q[6:0] == DEV_ADDR[7:1]);
                    ST_WORD, ST_WDATA: ack_q <= 1'b1;
                    default: ack_q <= 1'b0;
                endcase
            end
            if (bit_cnt_q == 4'h8) begin
                unique case (state_q)
                    ST_ADDR: begin
                        if (!ack_q) begin
                            state_q <= ST_IGNORE;
                        end else if (shift_q[0]) begin
                            state_q <= ST_RDATA;
                        end else begin
                            state_q <= ST_WORD;
                        end
                    end
                    ST_WORD: state_q <= ST_WDATA;
                    ST_RDATA: begin
                        if (i_sda_i) begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    // ------------------------
    // Address pointer and write hand-off (rising line clock)
    // ------------------------

    // Survives STOP so a bare read resumes where the pointer stands
    always_ff @(posedge i_scl or posedge prot_q) begin
        if (prot_q) begin
            ptr_q <= '0;
            wr_en_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
            xfer_tgl_q <= 1'b0;
        end else if (!link_clr_q && bit_cnt_q == 4'h8) begin
            unique case (state_q)
                ST_WORD: begin
                    ptr_q <= shift_q[5:0];
                    wr_en_q <= 1'b0;
                    xfer_tgl_q <= ~xfer_tgl_q;
                end
                ST_WDATA: begin
                    wr_en_q <= 1'b1;
                    wr_addr_q <= ptr_q;
                    wr_data_q <= shift_q;
                    ptr_q <= 6'(ptr_q + 6'h1);
                    xfer_tgl_q <= ~xfer_tgl_q;
                end
                ST_RDATA: begin
                    if (!i_sda_i) begin
                        ptr_q <= 6'(ptr_q + 6'h1);
                        wr_en_q <= 1'b0;
                        xfer_tgl_q <= ~xfer_tgl_q;
                    end
                end
                default: wr_en_q <= wr_en_q;
            endcase
        end
    end

    // ------------------------
    // Link drive side (falling line clock)
    // ------------------------

    // rd_byte_q settles within four system clocks of the rising line clock edge, before this edge samples it
    always_ff @(negedge i_scl or posedge link_clr_q) begin
        if (link_clr_q) begin
            sda_low_q <= 1'b0;
            tx_q <= '0;
            rd_busy_q <= 1'b0;
        end else begin
            rd_busy_q <= (state_q == ST_RDATA) && (ptr_q < IDX_CTRL);
            if (bit_cnt_q == 4'h0) begin
                tx_q <= rd_byte_q;
            end else if (bit_cnt_q < 4'h8) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
            if (bit_cnt_q == 4'h8) begin
                sda_low_q <= ack_q;
            end else if (state_q == ST_RDATA) begin
                sda_low_q <= (bit_cnt_q == 4'h0) ? ~rd_byte_q[7] : ~tx_q[6];
            end else begin
                sda_low_q <= 1'b0;
            end
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = sda_low_q;

    // ------------------------
    // Crossing into the system clock
    // ------------------------

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tgl_q <= '0;
            busy_q <= '0;
        end else if (prot_q) begin
            tgl_q <= '0;
            busy_q <= '0;
        end else begin
            tgl_q <= {tgl_q[1:0], xfer_tgl_q};
            busy_q <= {busy_q[0], rd_busy_q};
        end
    end
    assign xfer_fire = tgl_q[1] ^ tgl_q[2];
    assign ld_en = xfer_fire && wr_en_q && (wr_addr_q < IDX_CTRL);

    // ------------------------
    // Register file
    // ------------------------

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ptr_cap_q <= '0;
            ctrl_q <= CTRL_RESET;
        end else if (prot_q) begin
            ptr_cap_q <= '0;
        end else if (xfer_fire) begin
            ptr_cap_q <= ptr_q;
            if (wr_en_q && wr_addr_q == IDX_CTRL) begin
                ctrl_q <= wr_data_q;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (xfer_fire && wr_en_q && wr_addr_q >= IDX_RAM_LO) begin
            ram_q[wr_addr_q] <= wr_data_q;
        end
    end

    // Time is copied to the user view when no read of it is running, or once a read has held it back for DEFER_CYCLES
    assign copy_now = upd_pend_q && (!busy_q[1] || defer_cnt_q == 25'(DEFER_CYCLES - 1));

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            upd_pend_q <= 1'b0;
            defer_cnt_q <= '0;
        end else begin
            if (t_tick) begin
                upd_pend_q <= 1'b1;
            end else if (copy_now) begin
                upd_pend_q <= 1'b0;
            end
            if (!upd_pend_q || copy_now) begin
                defer_cnt_q <= '0;
            end else if (busy_q[1]) begin
                defer_cnt_q <= 25'(defer_cnt_q + 25'h1);
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < N_TIME; i++) begin
                shadow_q[i] <= '0;
            end
        end else if (copy_now) begin
            shadow_q[0] <= t_sec;
            shadow_q[1] <= t_min;
            shadow_q[2] <= t_hour;
            shadow_q[3] <= t_day;
            shadow_q[4] <= t_date;
            shadow_q[5] <= t_mon;
            shadow_q[6] <= t_year;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rd_byte_q <= '0;
        end else if (ptr_cap_q < IDX_CTRL) begin
            rd_byte_q <= shadow_q[ptr_cap_q[2:0]];
        end else if (ptr_cap_q == IDX_CTRL) begin
            rd_byte_q <= ctrl_q;
        end else begin
            rd_byte_q <= ram_q[ptr_cap_q];
        end
    end

    // ------------------------
    // Timekeeping and test pin
    // ------------------------

    rtc_timekeeper u_timekeeper (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_osc_32k(i_osc_32k),
        .i_ld_en(ld_en),
        .i_ld_idx(wr_addr_q[2:0]),
        .i_ld_data(wr_data_q),
        .i_cal(ctrl_q[5:0]),
        .o_sec(t_sec),
        .o_min(t_min),
        .o_hour(t_hour),
        .o_day(t_day),
        .o_date(t_date),
        .o_mon(t_mon),
        .o_year(t_year),
        .o_tick(t_tick),
        .o_wave(t_wave)
    );

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_test_or_level_pin_oe <= 1'b0;
        end else if (prot_q) begin
            o_test_or_level_pin_oe <= 1'b0;
        end else if (ctrl_q[FT_BIT]) begin
            o_test_or_level_pin_oe <= ~t_wave;
        end else begin
            o_test_or_level_pin_oe <= ~ctrl_q[OUT_BIT];
        end
    end
    assign o_test_or_level_pin_o = 1'b0;

endmodule : rtc_serial_clock

`default_nettype wire

// >>> rtc_serial_clock_bench.sv
// Self-checking bench for the serial-bus real-time clock
`default_nettype none

module rtc_serial_clock_bench
    import rtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROT = 50;
    logic i_clk_sys, i_rst, i_scl, i_sda_i, o_sda_o, o_sda_oe, i_osc_32k, i_below_power_fail_threshold;
    logic o_test_or_level_pin_o, o_test_or_level_pin_oe, m_low, p;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    logic [7:0] wdat [5] = '{8'hA5, 8'h12, 8'h59, 8'h23, 8'hFD};
    logic [7:0] rdat [5] = '{8'hA5, 8'h12, 8'h59, 8'h23, 8'h05};
    assign i_sda_i = !(m_low || (o_sda_oe && !o_sda_o));
    rtc_serial_clock #(.DEFER_CYCLES(200), .PROTECT_CYCLES(PROT)) rtc_serial_clock_inst (.i_clk_sys, .i_rst,
        .i_scl, .i_sda_i, .o_sda_o, .o_sda_oe, .i_osc_32k, .i_below_power_fail_threshold, .o_test_or_level_pin_o,
        .o_test_or_level_pin_oe);
    bus_master_model bus_master_model_inst (.o_scl(i_scl), .o_sda_low(m_low), .i_sda_line(i_sda_i));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = !i_clk_sys;
    end
    // Fast crystal so the test pin moves within the run; seconds never roll over
    initial begin
        i_osc_32k = 1'b0;
        forever #100 i_osc_32k = !i_osc_32k;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic send(input logic [7:0] v, input logic acked);
        logic [7:0] r;
        logic a;
        bus_master_model_inst.xfer(v, 1'b1, r, a);
        chk("ack", {7'h0, !acked}, {7'h0, a});
    endtask : send
    task automatic recv(input logic [7:0] exp, input logic last);
        logic [7:0] r;
        logic a;
        bus_master_model_inst.xfer(8'hFF, last, r, a);
        chk("read data", exp, r);
    endtask : recv
    task automatic head(input logic [7:0] a, input logic acked);
        bus_master_model_inst.begin_frame();
        send(a, acked);
    endtask : head
    task automatic stop_bus();
        bus_master_model_inst.end_frame();
        @(negedge i_clk_sys);
    endtask : stop_bus
    task automatic read_from(input logic [7:0] w);
        head(DEV_ADDR, 1'b1);
        send(w, 1'b1);
        head(DEV_ADDR | 8'h01, 1'b1);
    endtask : read_from
    task automatic wr_ctrl(input logic [7:0] v);
        head(DEV_ADDR, 1'b1);
        send({2'h0, IDX_CTRL}, 1'b1);
        send(v, 1'b1);
        stop_bus();
        repeat (5) @(negedge i_clk_sys);
    endtask : wr_ctrl
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
    initial begin
        i_rst = 1'b1;
        i_below_power_fail_threshold = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        i_rst = 1'b0;
        head(DEV_ADDR, 1'b0);
        stop_bus();
        repeat (PROT + 10) @(negedge i_clk_sys);
        chk("pin after reset", 8'h00, {7'h0, o_test_or_level_pin_oe});
        head(8'hA0, 1'b0);
        stop_bus();
        head(DEV_ADDR, 1'b1);
        send(8'h3F, 1'b1);
        for (int i = 0; i < 5; i++) send(wdat[i], 1'b1);
        stop_bus();
        read_from(8'h3F);
        for (int i = 0; i < 5; i++) recv(rdat[i], i == 4);
        stop_bus();
        head(DEV_ADDR | 8'h01, 1'b1);
        recv(8'h05, 1'b1);
        stop_bus();
        for (int i = 0; i < 2; i++) begin
            wr_ctrl(8'(i * 128));
            chk("pin level", {7'h0, i == 0}, {7'h0, o_test_or_level_pin_oe});
        end
        wr_ctrl(8'h40);
        n = 0;
        p = o_test_or_level_pin_oe;
        repeat (1400) begin
            @(negedge i_clk_sys);
            n += int'(o_test_or_level_pin_oe !== p);
            p = o_test_or_level_pin_oe;
        end
        chk("pin toggles", 8'h01, {7'h0, n >= 2 && n <= 3});
        read_from({2'h0, IDX_CTRL});
        recv(8'h40, 1'b1);
        stop_bus();
        i_below_power_fail_threshold = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        chk("pin in power fail", 8'h00, {7'h0, o_test_or_level_pin_oe});
        head(DEV_ADDR, 1'b0);
        stop_bus();
        i_below_power_fail_threshold = 1'b0;
        repeat (PROT + 10) @(negedge i_clk_sys);
        head(DEV_ADDR | 8'h01, 1'b1);
        recv(8'h12, 1'b1);
        stop_bus();
        complete_run();
    end
endmodule : rtc_serial_clock_bench

`default_nettype wire

// >>> rtc_serial_clock_props.sv
// Port-level checks for the serial-bus real-time clock
`default_nettype none

module rtc_serial_clock_props
    import rtc_pkg::*;
#(
    parameter int unsigned DEFER_CYCLES = DEFER_CYC,
    parameter int unsigned PROTECT_CYCLES = PROTECT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda_i,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic i_osc_32k,
    input wire logic i_below_power_fail_threshold,
    input wire logic o_test_or_level_pin_o,
    input wire logic o_test_or_level_pin_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [31:0] guard_q;
    // Cycles since reset or power fail ended, saturating
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            guard_q <= '0;
        end else if (i_below_power_fail_threshold) begin
            guard_q <= '0;
        end else if (guard_q < PROTECT_CYCLES) begin
            guard_q <= guard_q + 32'h1;
        end
    end
    sequence s_start; i_scl && $past(i_scl) && $fell(i_sda_i); endsequence
    sequence s_stop; i_scl && $past(i_scl) && $rose(i_sda_i); endsequence
    property p_sda_open; !o_sda_o; endproperty
    property p_held_high; disable iff (i_rst || i_below_power_fail_threshold) i_scl && $past(i_scl) |-> $stable(o_sda_oe); endproperty
    property p_ack_len; disable iff (i_rst || i_below_power_fail_threshold) $rose(o_sda_oe) |=> o_sda_oe [*8]; endproperty
    property p_start_quiet; s_start |-> !o_sda_oe [*8]; endproperty
    property p_stop_quiet; s_stop |-> !o_sda_oe [*8]; endproperty
    property p_pf_sda; i_below_power_fail_threshold [*5] |-> !o_sda_oe; endproperty
    property p_pf_pin; i_below_power_fail_threshold [*5] |-> !o_test_or_level_pin_oe; endproperty
    property p_protect; guard_q < PROTECT_CYCLES |-> !o_sda_oe; endproperty
    a_sda_open: assert property (p_sda_open) else $error("sda driven high");
    a_held_high: assert property (p_held_high) else $error("sda moved while scl high");
    a_ack_len: assert property (p_ack_len) else $error("sda low too short");
    a_start_quiet: assert property (p_start_quiet) else $error("sda driven after start");
    a_stop_quiet: assert property (p_stop_quiet) else $error("sda driven after stop");
    a_pf_sda: assert property (p_pf_sda) else $error("sda driven in power fail");
    a_pf_pin: assert property (p_pf_pin) else $error("pin driven in power fail");
    a_protect: assert property (p_protect) else $error("sda driven while protected");
endmodule : rtc_serial_clock_props

bind rtc_serial_clock rtc_serial_clock_props #(.DEFER_CYCLES(DEFER_CYCLES), .PROTECT_CYCLES(PROTECT_CYCLES))
    rtc_serial_clock_props_inst (.i_clk_sys, .i_rst, .i_scl, .i_sda_i, .o_sda_o, .o_sda_oe, .i_osc_32k,
    .i_below_power_fail_threshold, .o_test_or_level_pin_o, .o_test_or_level_pin_oe);

`default_nettype wire

// >>> rtc_timekeeper.sv
// BCD calendar counter with calibration, driven by the crystal input
`default_nettype none

module rtc_timekeeper
    import rtc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_osc_32k,
    input wire logic i_ld_en,
    input wire logic [2:0] i_ld_idx,
    input wire logic [7:0] i_ld_data,
    input wire logic [5:0] i_cal,
    output logic [7:0] o_sec,
    output logic [7:0] o_min,
    output logic [7:0] o_hour,
    output logic [7:0] o_day,
    output logic [7:0] o_date,
    output logic [7:0] o_mon,
    output logic [7:0] o_year,
    output logic o_tick,
    output logic o_wave
);

    logic [2:0] osc_q;
    logic [16:0] cnt_q;
    logic [16:0] sec_len;
    logic [5:0] cal_min_q;
    logic [4:0] wave_cnt_q;
    logic osc_en;
    logic sec_end;
    logic [8:0] s, m, h, wd, dt, mo, yr;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            osc_q <= '0;
        end else begin
            osc_q <= {osc_q[1:0], i_osc_32k};
        end
    end

    assign osc_en = osc_q[1] & ~osc_q[2] & ~o_sec[HALT_BIT];

    // One second per minute is trimmed in the first 2*n minutes of 64
    always_comb begin
        sec_len = 17'(OSC_HZ);
        if (o_sec[6:0] == 7'h00 && cal_min_q < {i_cal[4:0], 1'b0}) begin
            sec_len = i_cal[SIGN_BIT] ? 17'(OSC_HZ - CAL_ADD_CYC) : 17'(OSC_HZ + CAL_SUB_CYC);
        end
    end

    assign sec_end = osc_en && (cnt_q == 17'(sec_len - 17'h1));

    always_comb begin
        s = bcd_inc({1'b0, o_sec[6:0]}, 8'h00, 8'h59);
        m = bcd_inc(o_min, 8'h00, 8'h59);
        h = bcd_inc({2'b00, o_hour[5:0]}, 8'h00, 8'h23);
        wd = bcd_inc(o_day, 8'h01, 8'h07);
        dt = bcd_inc(o_date, 8'h01, month_len(o_mon, o_year));
        mo = bcd_inc(o_mon, 8'h01, 8'h12);
        yr = bcd_inc(o_year, 8'h00, 8'h99);
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
            cal_min_q <= '0;
            {o_sec, o_min, o_hour, o_day, o_date, o_mon, o_year} <= 56'h01010100;
        end else if (i_ld_en) begin
            unique case (i_ld_idx)
                3'h0: begin
                    o_sec <= i_ld_data;
                    cnt_q <= '0;
                end
                3'h1: o_min <= i_ld_data & MIN_MASK;
                3'h2: o_hour <= i_ld_data;
                3'h3: o_day <= i_ld_data & DAY_MASK;
                3'h4: o_date <= i_ld_data & DATE_MASK;
                3'h5: o_mon <= i_ld_data & MON_MASK;
                default: o_year <= i_ld_data;
            endcase
        end else if (osc_en) begin
            cnt_q <= sec_end ? 17'h0 : 17'(cnt_q + 17'h1);
            if (sec_end) begin
                o_sec[6:0] <= s[6:0];
                if (s[8]) begin
                    o_min <= m[7:0];
                    cal_min_q <= 6'(cal_min_q + 6'h1);
                    if (m[8]) begin
                        o_hour[5:0] <= h[5:0];
                        if (h[8]) begin
                            o_day <= wd[7:0];
                            o_date <= dt[7:0];
                            if (dt[8]) begin
                                o_mon <= mo[7:0];
                                if (mo[8]) begin
                                    o_year <= yr[7:0];
                                    if (yr[8] && o_hour[CEB_BIT]) begin
                                        o_hour[CB_BIT] <= ~o_hour[CB_BIT];
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // Free divider, untouched by calibration
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wave_cnt_q <= '0;
            o_wave <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= sec_end | i_ld_en;
            if (osc_en) begin
                wave_cnt_q <= (wave_cnt_q == 5'(WAVE_HALF - 1)) ? 5'h0 : 5'(wave_cnt_q + 5'h1);
                if (wave_cnt_q == 5'(WAVE_HALF - 1)) begin
                    o_wave <= ~o_wave;
                end
            end
        end
    end

endmodule : rtc_timekeeper

`default_nettype wire
